// [design/ttpc_channel.sv]
// Purpose: One timer channel with its pin synchroniser and pin driver
// Assumes: Pin input is asynchronous to clk
// Notes: Counter stops and pin freezes while stop is high
`timescale 1ns/10ps
module ttpc_channel #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Configuration
  input wire logic enable,
  input wire ttpc_pkg::ttpc_mode_type mode,
  input wire logic ext_clk_sel,
  input wire logic gpo_level,
  input wire logic [CNT_W-1:0] compare,
  input wire logic stop,
  // Pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe_n,
  output logic pin_keep,
  // State
  output logic pin_level,
  output logic [CNT_W-1:0] count,
  output logic tc_pulse
);

  logic [2:0] sync_q;
  logic pin_rise;
  logic dir_out;
  logic is_out;
  logic counting;
  logic tick;
  logic hit;

  ////////////////////////////////////////////////////////////////////////////
  // Pin input: ignored in reset and in stop
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      sync_q <= 3'h0;
    else if (!stop)
      sync_q <= {sync_q[1:0], pin_in};
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_level <= 1'b0;
      pin_rise <= 1'b0;
    end
    else
    begin
      pin_rise <= 1'b0;
      if (!stop && sync_q[1] == sync_q[2])
      begin
        pin_rise <= sync_q[2] & ~pin_level;
        pin_level <= sync_q[2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter
  always_comb
  begin
    is_out = mode inside {ttpc_pkg::TTPC_GPIO_OUT, ttpc_pkg::TTPC_TIMER,
                          ttpc_pkg::TTPC_WATCHDOG, ttpc_pkg::TTPC_PWM};
    counting = enable && !stop && mode != ttpc_pkg::TTPC_GPIO_IN
               && mode != ttpc_pkg::TTPC_GPIO_OUT;
    case (mode)
      ttpc_pkg::TTPC_EVENT: tick = ext_clk_sel ? pin_rise : 1'b1;
      ttpc_pkg::TTPC_MEASURE: tick = pin_level;
      default: tick = 1'b1; // Output modes count internal clocks only
    endcase
    hit = counting && tick && count == compare;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      count <= '0;
      tc_pulse <= 1'b0;
    end
    else
    begin
      tc_pulse <= hit;
      if (!enable || hit)
        count <= '0;
      else if (counting && tick)
        count <= count + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin driver; wait has no effect here since only mode and stop steer it
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      pin_out <= 1'b0;
      dir_out <= 1'b0;
      pin_oe_n <= 1'b1;
      pin_keep <= 1'b0;
    end
    else
    begin
      pin_oe_n <= stop || !is_out;
      pin_keep <= stop && dir_out;
      if (!stop)
      begin
        dir_out <= is_out;
        case (mode)
          ttpc_pkg::TTPC_GPIO_OUT: pin_out <= gpo_level;
          ttpc_pkg::TTPC_TIMER: pin_out <= pin_out ^ hit;
          ttpc_pkg::TTPC_WATCHDOG: pin_out <= hit;
          ttpc_pkg::TTPC_PWM: pin_out <= count < (compare >> 1);
          default: pin_out <= pin_out;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_out_mode_drives: assert property (@(posedge clk) disable iff (reset)
    (is_out && !stop) |=> !pin_oe_n) else $error("output mode pin not driven");
  a_stop_holds_pin: assert property (@(posedge clk) disable iff (reset)
    (stop && $past(stop)) |-> ($stable(pin_out) && $stable(count) && pin_oe_n))
    else $error("pin or count moved in stop");

endmodule

// [design/ttpc_pkg.sv]
// Purpose: Shared constants and types of the triple timer with pin control
// Assumes: 32-bit classic Wishbone register access, one clock
// Notes: Offsets are byte addresses of aligned 32-bit words
package ttpc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [7:0] OFS_TIMER_CTRL_STAT_CH0 = 8'h00;
  localparam logic [7:0] OFS_TIMER_CTRL_STAT_CH1 = 8'h10;
  localparam logic [7:0] OFS_TIMER_CTRL_STAT_CH2 = 8'h20;
  localparam logic [7:0] OFS_CH_BASE [0:2] = '{
    OFS_TIMER_CTRL_STAT_CH0, OFS_TIMER_CTRL_STAT_CH1, OFS_TIMER_CTRL_STAT_CH2};
  localparam logic [7:0] OFS_CMP_DELTA = 8'h04;
  localparam logic [7:0] OFS_CNT_DELTA = 8'h08;
  localparam logic [7:0] OFS_INT_STAT = 8'h30;
  localparam logic [7:0] OFS_INT_MASK = 8'h34;

  ////////////////////////////////////////////////////////////////////////////
  // Control/status field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 3;
  localparam int CTRL_GPO_BIT = 4;
  localparam int CTRL_EXT_BIT = 5;
  localparam int CTRL_W = 6;
  localparam int STAT_PIN_BIT = 8;
  localparam int STAT_TC_BIT = 9;
  localparam int STAT_KEEP_BIT = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [31:0] CMP_RESET = 32'h0000_0000;
  localparam logic [2:0] MASK_RESET = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [2:0] {
    TTPC_GPIO_IN = 3'h0,
    TTPC_GPIO_OUT = 3'h1,
    TTPC_EVENT = 3'h2,
    TTPC_MEASURE = 3'h3,
    TTPC_TIMER = 3'h4,
    TTPC_WATCHDOG = 3'h5,
    TTPC_PWM = 3'h6
  } ttpc_mode_type;

  typedef enum logic [1:0] {
    TTPC_BUS_IDLE = 2'b01,
    TTPC_BUS_ACK = 2'b10
  } ttpc_bus_type;

endpackage

// [design/ttpc_top.sv]
// Purpose: Three independent timer channels with pin direction control
// Assumes: Classic Wishbone slave, 32-bit data, one clock at 40 MHz
// Notes: stop_req freezes channels; keepers hold driven levels meanwhile
//
// Overview of operation
// - Three identical independent channels, own pin and register
// - Channel counts internal clock or pin events
// - Interrupt after a programmed event count
// - Drive pin after programmed internal event count
// - Event counter and measurement use pin as input
// - Watchdog, timer, pulse modes drive pin out
// - After reset pins are ignored general inputs
// - Control register selects GPIO output or timer use
// - Stop keeps each pin's last direction and state
// - Stop ignores inputs of input pins
// - Stop holds output level by weak keeper
// - Wait leaves pin direction and level alone
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/10ps
module ttpc_top #(
  parameter int CNT_W = 24,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Low-power state
  input wire logic stop_req,
  // Interrupt
  output logic irq,
  // Timer pin channel 0
  input wire logic timer_pin_ch0_in,
  output logic timer_pin_ch0_out,
  output logic timer_pin_ch0_oe_n,
  output logic timer_pin_ch0_keep,
  // Timer pin channel 1
  input wire logic timer_pin_ch1_in,
  output logic timer_pin_ch1_out,
  output logic timer_pin_ch1_oe_n,
  output logic timer_pin_ch1_keep,
  // Timer pin channel 2
  input wire logic timer_pin_ch2_in,
  output logic timer_pin_ch2_out,
  output logic timer_pin_ch2_oe_n,
  output logic timer_pin_ch2_keep
);

  localparam int NCH = 3;

  ttpc_pkg::ttpc_bus_type bus_state;
  ttpc_pkg::ttpc_bus_type next_bus_state;
  logic [7:0] adr;
  logic bus_req;
  logic wr_take;
  logic [31:0] rdata;
  logic [ttpc_pkg::CTRL_W-1:0] ctrl [NCH];
  logic [CNT_W-1:0] cmp [NCH];
  logic [CNT_W-1:0] count [NCH];
  logic [NCH-1:0] pin_in;
  logic [NCH-1:0] pin_out;
  logic [NCH-1:0] pin_oe_n;
  logic [NCH-1:0] pin_keep;
  logic [NCH-1:0] pin_level;
  logic [NCH-1:0] tc_pulse;
  logic [NCH-1:0] int_stat;
  logic [NCH-1:0] int_mask;
  logic [NCH-1:0] hit_ctrl;
  logic [NCH-1:0] hit_cmp;
  logic [NCH-1:0] hit_cnt;
  logic [31:0] next_ctrl_word [NCH];
  logic [31:0] next_cmp_word [NCH];

  function automatic logic [31:0] merge_lanes(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0] sel
  );
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
        r[8*b +: 8] = wd[8*b +: 8];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane merge of a write into each channel's register words
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      next_ctrl_word[i] = merge_lanes(32'(ctrl[i]), wb_dat_i, wb_sel_i);
      next_cmp_word[i] = merge_lanes(32'(cmp[i]), wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: ack one cycle after the request, writes land with ack
  assign adr = wb_adr_i[7:0];
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign wb_ack_o = bus_state == ttpc_pkg::TTPC_BUS_ACK;
  assign wr_take = wb_ack_o && bus_req && wb_we_i;

  always_comb
  begin
    case (bus_state)
      ttpc_pkg::TTPC_BUS_IDLE:
        next_bus_state = bus_req ? ttpc_pkg::TTPC_BUS_ACK : ttpc_pkg::TTPC_BUS_IDLE;
      ttpc_pkg::TTPC_BUS_ACK:
        next_bus_state = ttpc_pkg::TTPC_BUS_IDLE;
      default:
        next_bus_state = ttpc_pkg::TTPC_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      bus_state <= ttpc_pkg::TTPC_BUS_IDLE;
    else
      bus_state <= next_bus_state;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
    begin
      hit_ctrl[i] = adr == ttpc_pkg::OFS_CH_BASE[i];
      hit_cmp[i] = adr == (ttpc_pkg::OFS_CH_BASE[i] + ttpc_pkg::OFS_CMP_DELTA);
      hit_cnt[i] = adr == (ttpc_pkg::OFS_CH_BASE[i] + ttpc_pkg::OFS_CNT_DELTA);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped addresses read as zero but are still acknowledged
  always_comb
  begin
    rdata = 32'h0000_0000;
    for (int i = 0; i < NCH; i++)
    begin
      if (hit_ctrl[i])
      begin
        rdata[ttpc_pkg::CTRL_W-1:0] = ctrl[i];
        rdata[ttpc_pkg::STAT_PIN_BIT] = pin_level[i];
        rdata[ttpc_pkg::STAT_TC_BIT] = int_stat[i];
        rdata[ttpc_pkg::STAT_KEEP_BIT] = pin_keep[i];
      end
      if (hit_cmp[i])
        rdata[CNT_W-1:0] = cmp[i];
      if (hit_cnt[i])
        rdata[CNT_W-1:0] = count[i];
    end
    if (adr == ttpc_pkg::OFS_INT_STAT)
      rdata[NCH-1:0] = int_stat;
    if (adr == ttpc_pkg::OFS_INT_MASK)
      rdata[NCH-1:0] = int_mask;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      wb_dat_o <= 32'h0000_0000;
    else if (bus_state == ttpc_pkg::TTPC_BUS_IDLE && bus_req && !wb_we_i)
      wb_dat_o <= rdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel control/status and compare registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
        ctrl[i] <= ttpc_pkg::CTRL_RESET;
    end
    else if (wr_take)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (hit_ctrl[i])
          ctrl[i] <= next_ctrl_word[i][ttpc_pkg::CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      for (int i = 0; i < NCH; i++)
        cmp[i] <= ttpc_pkg::CMP_RESET[CNT_W-1:0];
    end
    else if (wr_take)
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (hit_cmp[i])
          cmp[i] <= next_cmp_word[i][CNT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt: sticky terminal-count flags, set beats a write-one clear
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      int_stat <= '0;
    else
    begin
      for (int i = 0; i < NCH; i++)
      begin
        if (tc_pulse[i])
          int_stat[i] <= 1'b1;
        else if (wr_take && adr == ttpc_pkg::OFS_INT_STAT && wb_sel_i[0] && wb_dat_i[i])
          int_stat[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      int_mask <= ttpc_pkg::MASK_RESET;
    else if (wr_take && adr == ttpc_pkg::OFS_INT_MASK && wb_sel_i[0])
      int_mask <= wb_dat_i[NCH-1:0];
  end

  assign irq = |(int_stat & int_mask);

  ////////////////////////////////////////////////////////////////////////////
  // Channels, identical and independent
  assign pin_in = {timer_pin_ch2_in, timer_pin_ch1_in, timer_pin_ch0_in};

  for (genvar g = 0; g < NCH; g++)
  begin : g_ch
    ttpc_channel #(
      .CNT_W(CNT_W)
    ) u_ch (
      .clk(clk),
      .reset(reset),
      .enable(ctrl[g][ttpc_pkg::CTRL_EN_BIT]),
      .mode(ttpc_pkg::ttpc_mode_type'(ctrl[g][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB])),
      .ext_clk_sel(ctrl[g][ttpc_pkg::CTRL_EXT_BIT]),
      .gpo_level(ctrl[g][ttpc_pkg::CTRL_GPO_BIT]),
      .compare(cmp[g]),
      .stop(stop_req),
      .pin_in(pin_in[g]),
      .pin_out(pin_out[g]),
      .pin_oe_n(pin_oe_n[g]),
      .pin_keep(pin_keep[g]),
      .pin_level(pin_level[g]),
      .count(count[g]),
      .tc_pulse(tc_pulse[g])
    );
  end

  assign timer_pin_ch0_out = pin_out[0];
  assign timer_pin_ch1_out = pin_out[1];
  assign timer_pin_ch2_out = pin_out[2];
  assign timer_pin_ch0_oe_n = pin_oe_n[0];
  assign timer_pin_ch1_oe_n = pin_oe_n[1];
  assign timer_pin_ch2_oe_n = pin_oe_n[2];
  assign timer_pin_ch0_keep = pin_keep[0];
  assign timer_pin_ch1_keep = pin_keep[1];
  assign timer_pin_ch2_keep = pin_keep[2];

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  a_reset_pins_input: assert property (@(posedge clk) disable iff (reset)
    $past(reset) |-> (&pin_oe_n && !(|pin_keep) && !(|pin_level)))
    else $error("pin not an ignored input after reset");

  a_ack_single: assert property (@(posedge clk) disable iff (reset)
    (bus_req && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a one-cycle answer");

  a_read_data_taken: assert property (@(posedge clk) disable iff (reset)
    (bus_req && !wb_we_i && !wb_ack_o) |=> wb_dat_o == $past(rdata))
    else $error("read data not loaded at take");

  a_ctrl_write_lands: assert property (@(posedge clk) disable iff (reset)
    (wr_take && hit_ctrl[0] && wb_sel_i[0])
    |=> ctrl[0] == $past(wb_dat_i[ttpc_pkg::CTRL_W-1:0]))
    else $error("control write lost");

  a_tc_raises_irq: assert property (@(posedge clk) disable iff (reset)
    (tc_pulse[0] && int_mask[0]) |=> irq)
    else $error("terminal count did not raise irq");

  a_w1c_clears: assert property (@(posedge clk) disable iff (reset)
    (wr_take && adr == ttpc_pkg::OFS_INT_STAT && wb_sel_i[0] && wb_dat_i[0] && !tc_pulse[0])
    |=> !int_stat[0])
    else $error("write one did not clear status");

  a_tc_at_compare: assert property (@(posedge clk) disable iff (reset)
    tc_pulse[1] |-> (count[1] == '0 && $past(count[1]) == $past(cmp[1])))
    else $error("terminal count without compare match");

  a_timer_toggles: assert property (@(posedge clk) disable iff (reset)
    (ctrl[0][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h4 && !stop_req)
    |=> pin_out[0] == ($past(pin_out[0]) ^ tc_pulse[0]))
    else $error("timer pin did not toggle on match");

  a_pwm_level: assert property (@(posedge clk) disable iff (reset)
    (ctrl[2][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h6 && !stop_req)
    |=> pin_out[2] == ($past(count[2]) < ($past(cmp[2]) >> 1)))
    else $error("pulse level wrong");

  a_watchdog_pulse: assert property (@(posedge clk) disable iff (reset)
    (ctrl[2][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h5 && !stop_req)
    |=> pin_out[2] == tc_pulse[2])
    else $error("watchdog pin not the match pulse");

  a_measure_holds: assert property (@(posedge clk) disable iff (reset)
    (ctrl[2][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h3
     && ctrl[2][ttpc_pkg::CTRL_EN_BIT] && !pin_level[2])
    |=> $stable(count[2]))
    else $error("measure counted with pin low");

  a_input_mode_hiz: assert property (@(posedge clk) disable iff (reset)
    (ctrl[1][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h2 && !stop_req)
    |=> pin_oe_n[1])
    else $error("event mode pin driven");

  a_stop_keeper: assert property (@(posedge clk) disable iff (reset)
    (stop_req && !pin_oe_n[0]) |=> (pin_oe_n[0] && pin_keep[0] && $stable(pin_out[0])))
    else $error("keeper not holding in stop");

  a_stop_tristates: assert property (@(posedge clk) disable iff (reset)
    stop_req |=> &pin_oe_n)
    else $error("pin driver on in stop");

  a_stop_ignores_in: assert property (@(posedge clk) disable iff (reset)
    stop_req [*3] |-> $stable(pin_level))
    else $error("pin input seen in stop");

  a_gpo_follows: assert property (@(posedge clk) disable iff (reset)
    (ctrl[0][ttpc_pkg::CTRL_MODE_MSB:ttpc_pkg::CTRL_MODE_LSB] == 3'h1 && !stop_req)
    |=> (!pin_oe_n[0] && pin_out[0] == $past(ctrl[0][ttpc_pkg::CTRL_GPO_BIT])))
    else $error("gpio output not driven");

  a_status_sticky: assert property (@(posedge clk) disable iff (reset)
    (int_stat[2] && !(wr_take && adr == ttpc_pkg::OFS_INT_STAT)) |=> int_stat[2])
    else $error("status bit lost");

endmodule

// [verification/ttpc_pin_partner.sv]
// Purpose: External event source standing on the three timer pins
// Assumes: Pin level is the device drive when enabled, else this source
// Notes: Pulses last 4 clk high and 5 low between pulses (4 after the last), above the 3-flop filter
`timescale 1ns/10ps
module ttpc_pin_partner (
  // Clock
  input wire logic clk,
  // Device side of the pins
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe_n,
  // Resolved pin levels
  output logic [2:0] pin_wire
);
  logic [2:0] drv;
  initial drv = 3'h0;
  // Source yields the line while the device drives it
  assign pin_wire = (pin_oe_n & drv) | (~pin_oe_n & pin_out);
  task automatic pulse(input int ch, input int n);
    repeat (n)
    begin
      @(posedge clk);
      drv[ch] <= 1'b1;
      repeat (4) @(posedge clk);
      drv[ch] <= 1'b0;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic set_level(input int ch, input logic lv);
    @(posedge clk);
    drv[ch] <= lv;
  endtask
endmodule

// [verification/ttpc_top_tb_top.sv]
// Purpose: Self-checking bench of the triple timer with pin control
// Assumes: Ack one cycle after the take edge, masters hold until ack
// Notes: Random compare values, fixed seed; small values keep runs short
`timescale 1ns/10ps
module ttpc_top_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic stop = 1'b0;
  logic irq;
  logic [2:0] p_out, p_oe_n, p_keep, p_wire;
  int fail_count = 0;
  int num_checks = 0;
  int cmp;
  int n;
  logic [31:0] rd;
  logic lv;
  always #12.5 clk = ~clk;
  ttpc_top DUT (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stop_req(stop), .irq(irq),
    .timer_pin_ch0_in(p_wire[0]), .timer_pin_ch0_out(p_out[0]),
    .timer_pin_ch0_oe_n(p_oe_n[0]), .timer_pin_ch0_keep(p_keep[0]),
    .timer_pin_ch1_in(p_wire[1]), .timer_pin_ch1_out(p_out[1]),
    .timer_pin_ch1_oe_n(p_oe_n[1]), .timer_pin_ch1_keep(p_keep[1]),
    .timer_pin_ch2_in(p_wire[2]), .timer_pin_ch2_out(p_out[2]),
    .timer_pin_ch2_oe_n(p_oe_n[2]), .timer_pin_ch2_keep(p_keep[2]));
  ttpc_pin_partner part (.clk(clk), .pin_out(p_out), .pin_oe_n(p_oe_n), .pin_wire(p_wire));
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    t = 0;
    // Hold the request until ack is sampled high
    do
    begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (t >= 50) chk(32'h1, 32'h0);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  function automatic logic [31:0] ctl(input int m, input logic en, input logic g, input logic x);
    return {26'h0, x, g, m[2:0], en};
  endfunction
  function automatic logic [7:0] base(input int ch, input logic [7:0] d);
    return ttpc_pkg::OFS_CH_BASE[ch] + d;
  endfunction
  // Output modes: gpio out, timer, watchdog, pulse; all others leave the pin an input
  function automatic logic exp_oe_n(input int m);
    return !(m inside {1, 4, 5, 6});
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #(25 * 30000);
    fail_count++;
    complete_run();
  end
  initial
  begin
    void'($urandom(50579));
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    chk({29'h0, p_oe_n}, 32'h7);
    chk({29'h0, p_out | p_keep}, 32'h0);
    for (int c = 0; c < 3; c++)
    begin
      wb(1'b0, base(c, 8'h00), 32'h0);
      chk(rd & 32'h3F, 32'h0);
    end
    wb(1'b0, 8'h3C, 32'h0);
    chk(rd, 32'h0);
    // Direction follows mode for every mode
    for (int m = 0; m < 8; m++)
    begin
      wb(1'b1, base(2, 8'h04), 32'h0000_FFFF);
      wb(1'b1, base(2, 8'h00), ctl(m, 1'b1, 1'b0, 1'b0));
      repeat (2) @(posedge clk);
      chk(p_oe_n[2], exp_oe_n(m));
    end
    // Park ch2 so its count restarts from zero for the timer test
    wb(1'b1, base(2, 8'h00), 32'h0);
    // General output and input through the control register
    for (int i = 0; i < 4; i++)
    begin
      lv = $urandom_range(0, 1);
      wb(1'b1, base(0, 8'h00), ctl(1, 1'b0, lv, 1'b0));
      repeat (2) @(posedge clk);
      chk({p_oe_n[0], p_out[0]}, {1'b0, lv});
      wb(1'b1, base(0, 8'h00), ctl(0, 1'b0, 1'b0, 1'b0));
      part.set_level(0, ~lv);
      repeat (6) @(posedge clk);
      wb(1'b0, base(0, 8'h00), 32'h0);
      chk(rd[ttpc_pkg::STAT_PIN_BIT], {31'h0, ~lv});
    end
    // Timer mode: interrupt, compare match and pin toggle on each channel
    wb(1'b1, {2'h0, ttpc_pkg::OFS_INT_MASK[5:0]}, 32'h7);
    for (int c = 0; c < 3; c++)
    begin
      cmp = $urandom_range(3, 12);
      wb(1'b1, base(c, 8'h04), cmp);
      lv = p_out[c];
      wb(1'b1, base(c, 8'h00), ctl(4, 1'b1, 1'b0, 1'b0));
      n = 0;
      while (irq !== 1'b1 && n < cmp + 20)
      begin
        @(posedge clk);
        n++;
      end
      chk(n >= cmp && n <= cmp + 6, 1'b1);
      repeat (2) @(posedge clk);
      chk(p_out[c], {31'h0, ~lv});
      wb(1'b1, base(c, 8'h00), 32'h0);
      wb(1'b0, ttpc_pkg::OFS_INT_STAT, 32'h0);
      chk(rd & 32'h7, 32'h1 << c);
      wb(1'b1, ttpc_pkg::OFS_INT_STAT, 32'h1 << c);
      @(posedge clk);
      chk(irq, 1'b0);
    end
    // External events on ch1 while ch0 drives a level, then stop
    cmp = $urandom_range(6, 10);
    wb(1'b1, base(1, 8'h04), cmp);
    wb(1'b1, base(1, 8'h00), ctl(2, 1'b1, 1'b0, 1'b1));
    wb(1'b1, base(0, 8'h00), ctl(1, 1'b0, 1'b1, 1'b0));
    part.pulse(1, 2);
    wb(1'b0, base(1, 8'h08), 32'h0);
    chk(rd, 32'h2);
    @(posedge clk);
    stop <= 1'b1;
    repeat (3) @(posedge clk);
    chk({p_oe_n[0], p_keep[0], p_out[0]}, 3'h7);
    chk({p_oe_n[1], p_keep[1]}, 2'b10);
    part.pulse(1, 3);
    @(posedge clk);
    stop <= 1'b0;
    repeat (3) @(posedge clk);
    wb(1'b0, base(1, 8'h08), 32'h0);
    chk(rd, 32'h2);
    chk({p_oe_n[0], p_out[0]}, 2'b01);
    part.pulse(1, cmp);
    wb(1'b0, ttpc_pkg::OFS_INT_STAT, 32'h0);
    chk(rd & 32'h7, 32'h2);
    complete_run();
  end
endmodule
